//--- mtc_config_regs.sv
`timescale 1ns/100ps
// Summary of operation
// R1: Stop-on-trigger ends monitoring on trigger word match.
// R2: External select starts monitor on input rising edge.
// R3: External start also needs trigger enable set.
// R4: Bit 2 reads monitor enabled, resets zero.
// R5: Bit 1 set when triggered by match or edge.
// R6: Bit 0 set once monitoring has started.
// R7: Config two bit 15 selects enhanced interrupts.
// R8: Config two bit 14 enables RAM parity checking.
// R9: Config two bit 13 enables busy lookup table.
// R10: Config two bit 12 enables receive double buffering.
// R11: Config two bit 11 overwrites invalid circular data.
// R12: Bit 10 zero wraps buffers after 256 words.
// R13: Bits 9 to 7 select time-tag resolution.
// R14: Trigger enable required before any triggered start.
// R15: Start-on-trigger begins monitoring on trigger word match.
// R16: Resolution codes map 64us down to external clock.
// R17: Unused config one bits read zero, ignore writes.
module mtc_config_regs #(
    parameter int ADDR_W = 8
) (
    input  wire logic              ref_clk_i,                // Device clock, 20 MHz.
    input  wire logic              sys_rst_i,                // Synchronous reset, active high.
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,           // Write address.
    input  wire logic              s_axi_awvalid_i,          // Write address valid.
    output logic                   s_axi_awready_o,          // Write address ready.
    input  wire logic [31:0]       s_axi_wdata_i,            // Write data.
    input  wire logic [3:0]        s_axi_wstrb_i,            // Write byte strobes.
    input  wire logic              s_axi_wvalid_i,           // Write data valid.
    output logic                   s_axi_wready_o,           // Write data ready.
    output logic [1:0]             s_axi_bresp_o,            // Write response.
    output logic                   s_axi_bvalid_o,           // Write response valid.
    input  wire logic              s_axi_bready_i,           // Write response ready.
    input  wire logic [ADDR_W-1:0] s_axi_araddr_i,           // Read address.
    input  wire logic              s_axi_arvalid_i,          // Read address valid.
    output logic                   s_axi_arready_o,          // Read address ready.
    output logic [31:0]            s_axi_rdata_o,            // Read data.
    output logic [1:0]             s_axi_rresp_o,            // Read response.
    output logic                   s_axi_rvalid_o,           // Read data valid.
    input  wire logic              s_axi_rready_i,           // Read data ready.
    input  wire logic              monitor_enable_i,         // Word monitor enabled by mode logic.
    input  wire logic              rx_word_valid_i,          // One-cycle strobe: valid word received.
    input  wire logic [15:0]       rx_word_i,                // Received word.
    input  wire logic              external_start_input_i,   // External trigger input level.
    output logic                   monitor_active_o,         // Word monitor is monitoring.
    output logic                   enhanced_irq_enable_o,    // Enhanced interrupt behaviour.
    output logic                   ram_parity_enable_o,      // RAM parity checking on.
    output logic                   busy_table_enable_o,      // Busy lookup table in use.
    output logic                   double_buffer_enable_o,   // Receive double buffering on.
    output logic                   overwrite_invalid_enable_o, // Overwrite invalid circular data.
    output logic                   buffer_wrap_256_o,        // Buffers wrap after 256 words.
    output logic [2:0]             time_tag_res_o,           // Time-tag resolution code.
    output logic                   irq_o                     // Level interrupt, active high.
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        mtc_pkg::mtc_cfg1_t          cfg1;
        mtc_pkg::mtc_cfg2_t          cfg2;
        logic [15:0]                 trigger_word;
        logic [mtc_pkg::IRQ_BITS-1:0] irq_status;
        logic [mtc_pkg::IRQ_BITS-1:0] irq_mask;
        logic                        irq;
        logic                        mon_en;
        logic                        mon_triggered;
        logic                        mon_active;
        logic                        mon_stopped;
        logic                        ext_prev;
        logic                        aw_ready;
        logic                        w_ready;
        logic                        ar_ready;
        logic [ADDR_W-1:0]           waddr;
        logic [15:0]                 wdata;
        logic [1:0]                  wstrb;
        logic                        bvalid;
        logic [1:0]                  bresp;
        logic                        rvalid;
        logic [31:0]                 rdata;
        logic [1:0]                  rresp;
    } mtc_state_t;

    mtc_state_t st;
    mtc_state_t next_st;

    // Every address bit is decoded; no aliases.
    function automatic logic mtc_hit(input logic [ADDR_W-1:0] a, input logic [7:0] reg_addr);
        mtc_hit = (a == ADDR_W'(reg_addr));
    endfunction

    function automatic logic [15:0] mtc_merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                              input logic [1:0] be);
        mtc_merge = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
    endfunction

    logic [15:0] cfg1_word;
    logic [15:0] cfg2_word;
    logic        word_match;
    logic        ext_rise;
    logic        start_armed;
    logic        start_event;
    logic        stop_event;
    logic        trig_event;
    logic [mtc_pkg::IRQ_BITS-1:0] irq_set;
    logic [mtc_pkg::IRQ_BITS-1:0] irq_clr;
    logic [15:0] merged;

    always_comb begin
        cfg1_word = 16'h0000; // [R17]
        cfg1_word[mtc_pkg::C1_TRIGGER_ENABLE]    = st.cfg1.trigger_enable;
        cfg1_word[mtc_pkg::C1_START_ON_TRIGGER]  = st.cfg1.start_on_trigger;
        cfg1_word[mtc_pkg::C1_STOP_ON_TRIGGER]   = st.cfg1.stop_on_trigger;
        cfg1_word[mtc_pkg::C1_EXT_START_SELECT]  = st.cfg1.external_start_select;
        cfg1_word[mtc_pkg::C1_MONITOR_ENABLED]   = st.mon_en; // [R4]
        cfg1_word[mtc_pkg::C1_MONITOR_TRIGGERED] = st.mon_triggered; // [R5]
        cfg1_word[mtc_pkg::C1_MONITOR_ACTIVE]    = st.mon_active; // [R6]
        cfg2_word = {st.cfg2.enhanced_irq_enable, st.cfg2.ram_parity_enable, st.cfg2.busy_table_enable,
                     st.cfg2.double_buffer_enable, st.cfg2.overwrite_invalid_enable,
                     st.cfg2.buffer_wrap_control, st.cfg2.tt_res, 7'h00};
    end

    // ****************************************************************
    // Word monitor start and stop
    // ****************************************************************
    always_comb begin
        word_match  = rx_word_valid_i && (rx_word_i == st.trigger_word);
        ext_rise    = external_start_input_i && !st.ext_prev;
        // A monitor with no triggered start configured runs as soon as it is enabled.
        start_armed = st.cfg1.trigger_enable && (st.cfg1.start_on_trigger || st.cfg1.external_start_select); // [R14]
        start_event = st.mon_en && !st.mon_active && !st.mon_stopped &&
                      (!start_armed ||
                       (st.cfg1.trigger_enable && st.cfg1.start_on_trigger && word_match) || // [R15]
                       (st.cfg1.trigger_enable && st.cfg1.external_start_select && ext_rise)); // [R2] [R3]
        stop_event  = st.mon_en && st.mon_active && st.cfg1.stop_on_trigger && word_match; // [R1]
        trig_event  = st.mon_en && st.cfg1.trigger_enable &&
                      ((word_match && (st.cfg1.start_on_trigger || st.cfg1.stop_on_trigger)) ||
                       (st.cfg1.external_start_select && ext_rise)); // [R5]
        irq_set = '0;
        irq_set[mtc_pkg::IRQ_TRIGGERED] = trig_event;
        irq_set[mtc_pkg::IRQ_STARTED]   = start_event && start_armed;
        irq_set[mtc_pkg::IRQ_STOPPED]   = stop_event;
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_st  = st;
        irq_clr  = '0;
        merged   = 16'h0000;

        next_st.ext_prev = external_start_input_i;
        next_st.mon_en   = monitor_enable_i; // [R4]
        if (!st.mon_en) begin
            next_st.mon_triggered = 1'b0;
            next_st.mon_active    = 1'b0;
            next_st.mon_stopped   = 1'b0;
        end else begin
            if (trig_event) begin
                next_st.mon_triggered = 1'b1; // [R5]
            end
            if (start_event) begin
                next_st.mon_active = 1'b1; // [R6]
            end
            if (stop_event) begin
                next_st.mon_active  = 1'b0; // [R1]
                next_st.mon_stopped = 1'b1;
            end
        end

        // Write channel: address and data are taken in either order.
        if (st.aw_ready && s_axi_awvalid_i) begin
            next_st.aw_ready = 1'b0;
            next_st.waddr    = s_axi_awaddr_i;
        end
        if (st.w_ready && s_axi_wvalid_i) begin
            next_st.w_ready = 1'b0;
            next_st.wdata   = s_axi_wdata_i[15:0];
            next_st.wstrb   = s_axi_wstrb_i[1:0];
        end
        if (!st.aw_ready && !st.w_ready && !st.bvalid) begin
            next_st.bvalid = 1'b1;
            next_st.bresp  = mtc_pkg::RESP_OKAY;
            if (mtc_hit(st.waddr, mtc_pkg::ADDR_CONFIG_ONE)) begin
                merged = mtc_merge(cfg1_word, st.wdata, st.wstrb);
                next_st.cfg1.trigger_enable        = merged[mtc_pkg::C1_TRIGGER_ENABLE];
                next_st.cfg1.start_on_trigger      = merged[mtc_pkg::C1_START_ON_TRIGGER];
                next_st.cfg1.stop_on_trigger       = merged[mtc_pkg::C1_STOP_ON_TRIGGER];
                next_st.cfg1.external_start_select = merged[mtc_pkg::C1_EXT_START_SELECT];
            end else if (mtc_hit(st.waddr, mtc_pkg::ADDR_CONFIG_TWO)) begin
                merged = mtc_merge(cfg2_word, st.wdata, st.wstrb);
                next_st.cfg2 = merged[15:mtc_pkg::C2_LOW_FIELD]; // [R7] [R8] [R9] [R10] [R11] [R12] [R13]
            end else if (mtc_hit(st.waddr, mtc_pkg::ADDR_TRIGGER_WORD)) begin
                next_st.trigger_word = mtc_merge(st.trigger_word, st.wdata, st.wstrb);
            end else if (mtc_hit(st.waddr, mtc_pkg::ADDR_IRQ_STATUS)) begin
                irq_clr = st.wstrb[0] ? st.wdata[mtc_pkg::IRQ_BITS-1:0] : '0;
            end else if (mtc_hit(st.waddr, mtc_pkg::ADDR_IRQ_MASK)) begin
                if (st.wstrb[0]) begin
                    next_st.irq_mask = st.wdata[mtc_pkg::IRQ_BITS-1:0];
                end
            end else begin
                next_st.bresp = mtc_pkg::RESP_SLVERR;
            end
        end
        if (st.bvalid && s_axi_bready_i) begin
            next_st.bvalid   = 1'b0;
            next_st.aw_ready = 1'b1;
            next_st.w_ready  = 1'b1;
        end

        // Setting wins over a write-one clear in the same cycle.
        next_st.irq_status = (st.irq_status & ~irq_clr) | irq_set;
        next_st.irq        = |(next_st.irq_status & next_st.irq_mask);

        // Read channel: data is returned one cycle after the address is taken.
        if (st.ar_ready && s_axi_arvalid_i) begin
            next_st.ar_ready = 1'b0;
            next_st.rvalid   = 1'b1;
            next_st.rresp    = mtc_pkg::RESP_OKAY;
            next_st.rdata    = 32'h0000_0000;
            if (mtc_hit(s_axi_araddr_i, mtc_pkg::ADDR_CONFIG_ONE)) begin
                next_st.rdata[15:0] = cfg1_word;
            end else if (mtc_hit(s_axi_araddr_i, mtc_pkg::ADDR_CONFIG_TWO)) begin
                next_st.rdata[15:0] = cfg2_word;
            end else if (mtc_hit(s_axi_araddr_i, mtc_pkg::ADDR_TRIGGER_WORD)) begin
                next_st.rdata[15:0] = st.trigger_word;
            end else if (mtc_hit(s_axi_araddr_i, mtc_pkg::ADDR_IRQ_STATUS)) begin
                next_st.rdata[mtc_pkg::IRQ_BITS-1:0] = st.irq_status;
            end else if (mtc_hit(s_axi_araddr_i, mtc_pkg::ADDR_IRQ_MASK)) begin
                next_st.rdata[mtc_pkg::IRQ_BITS-1:0] = st.irq_mask;
            end else begin
                next_st.rresp = mtc_pkg::RESP_SLVERR;
            end
        end
        if (st.rvalid && s_axi_rready_i) begin
            next_st.rvalid   = 1'b0;
            next_st.ar_ready = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            st          <= '0;
            st.cfg2     <= mtc_pkg::C2_RESET;
            st.aw_ready <= 1'b1;
            st.w_ready  <= 1'b1;
            st.ar_ready <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign s_axi_awready_o            = st.aw_ready;
    assign s_axi_wready_o             = st.w_ready;
    assign s_axi_bresp_o              = st.bresp;
    assign s_axi_bvalid_o             = st.bvalid;
    assign s_axi_arready_o            = st.ar_ready;
    assign s_axi_rdata_o              = st.rdata;
    assign s_axi_rresp_o              = st.rresp;
    assign s_axi_rvalid_o             = st.rvalid;
    assign monitor_active_o           = st.mon_active; // [R6]
    assign enhanced_irq_enable_o      = st.cfg2.enhanced_irq_enable; // [R7]
    assign ram_parity_enable_o        = st.cfg2.ram_parity_enable; // [R8]
    assign busy_table_enable_o        = st.cfg2.busy_table_enable; // [R9]
    assign double_buffer_enable_o     = st.cfg2.double_buffer_enable; // [R10]
    assign overwrite_invalid_enable_o = st.cfg2.overwrite_invalid_enable; // [R11]
    assign buffer_wrap_256_o          = !st.cfg2.buffer_wrap_control; // [R12]
    assign time_tag_res_o             = st.cfg2.tt_res; // [R13] [R16]
    assign irq_o                      = st.irq;

endmodule

//--- mtc_pkg.sv
package mtc_pkg;

    // ****************************************************************
    // Register map: indices and byte addresses
    // ****************************************************************
    localparam logic [7:0] IDX_CONFIG_ONE   = 8'h01;
    localparam logic [7:0] IDX_CONFIG_TWO   = 8'h02;
    localparam logic [7:0] IDX_TRIGGER_WORD = 8'h0D;
    localparam logic [7:0] IDX_IRQ_STATUS   = 8'h20;
    localparam logic [7:0] IDX_IRQ_MASK     = 8'h21;
    localparam logic [7:0] ADDR_CONFIG_ONE   = {IDX_CONFIG_ONE[5:0], 2'b00};
    localparam logic [7:0] ADDR_CONFIG_TWO   = {IDX_CONFIG_TWO[5:0], 2'b00};
    localparam logic [7:0] ADDR_TRIGGER_WORD = {IDX_TRIGGER_WORD[5:0], 2'b00};
    localparam logic [7:0] ADDR_IRQ_STATUS   = {IDX_IRQ_STATUS[5:0], 2'b00};
    localparam logic [7:0] ADDR_IRQ_MASK     = {IDX_IRQ_MASK[5:0], 2'b00};

    // ****************************************************************
    // Field positions of the first configuration register
    // ****************************************************************
    localparam int C1_TRIGGER_ENABLE   = 11;
    localparam int C1_START_ON_TRIGGER = 10;
    localparam int C1_STOP_ON_TRIGGER  = 9;
    localparam int C1_EXT_START_SELECT = 7;
    localparam int C1_MONITOR_ENABLED  = 2;
    localparam int C1_MONITOR_TRIGGERED = 1;
    localparam int C1_MONITOR_ACTIVE   = 0;

    // ****************************************************************
    // Field positions of the second configuration register
    // ****************************************************************
    localparam int C2_ENHANCED_IRQ  = 15;
    localparam int C2_RAM_PARITY    = 14;
    localparam int C2_BUSY_TABLE    = 13;
    localparam int C2_DOUBLE_BUFFER = 12;
    localparam int C2_OVERWRITE_INV = 11;
    localparam int C2_BUFFER_WRAP   = 10;
    localparam int C2_TT_RES_LSB    = 7;
    localparam int C2_LOW_FIELD     = 7;
    localparam logic [8:0] C2_RESET = 9'h000;

    // Buffer length after which data buffers wrap while the wrap bit is zero.
    localparam int BUFFER_WRAP_WORDS = 256;

    // ****************************************************************
    // Time-tag resolution encodings
    // ****************************************************************
    localparam logic [2:0] TT_RES_64US   = 3'h0;
    localparam logic [2:0] TT_RES_32US   = 3'h1;
    localparam logic [2:0] TT_RES_16US   = 3'h2;
    localparam logic [2:0] TT_RES_8US    = 3'h3;
    localparam logic [2:0] TT_RES_4US    = 3'h4;
    localparam logic [2:0] TT_RES_2US    = 3'h5;
    localparam logic [2:0] TT_RES_SW     = 3'h6;
    localparam logic [2:0] TT_RES_EXTCLK = 3'h7;

    // ****************************************************************
    // Interrupt status bits
    // ****************************************************************
    localparam int IRQ_TRIGGERED = 0;
    localparam int IRQ_STARTED   = 1;
    localparam int IRQ_STOPPED   = 2;
    localparam int IRQ_BITS      = 3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       enhanced_irq_enable;
        logic       ram_parity_enable;
        logic       busy_table_enable;
        logic       double_buffer_enable;
        logic       overwrite_invalid_enable;
        logic       buffer_wrap_control;
        logic [2:0] tt_res;
    } mtc_cfg2_t;

    typedef struct packed {
        logic       trigger_enable;
        logic       start_on_trigger;
        logic       stop_on_trigger;
        logic       external_start_select;
    } mtc_cfg1_t;

endpackage

//--- mtc_config_regs_monitor.sv
`timescale 1ns/100ps
module mtc_config_regs_monitor (
    input wire logic       ref_clk_i, sys_rst_i, s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i,
    input wire logic       s_axi_wready_o, s_axi_bvalid_o, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o,
    input wire logic       monitor_enable_i, rx_word_valid_i, external_start_input_i, monitor_active_o,
    input wire logic       enhanced_irq_enable_o, buffer_wrap_256_o, irq_o,
    input wire logic [2:0] time_tag_res_o
);
    // Reset level at the previous edge marks the first edge after release.
    logic rst_q;
    always_ff @(posedge ref_clk_i) rst_q <= sys_rst_i;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    AST_RST_VALUES: assert property (rst_q && !sys_rst_i |-> buffer_wrap_256_o && !irq_o
        && !monitor_active_o && !enhanced_irq_enable_o && time_tag_res_o == 3'h0)
        else $error("bad reset values");
    AST_CFG_ON_WRITE: assert property (!$stable({enhanced_irq_enable_o, buffer_wrap_256_o, time_tag_res_o})
        |-> $rose(s_axi_bvalid_o)) else $error("config changed without write");
    AST_AW_TAKE: assert property (s_axi_awvalid_i && s_axi_awready_o |=> !s_axi_awready_o)
        else $error("awready stayed high after take");
    AST_B_LAT: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
        |-> ##2 s_axi_bvalid_o) else $error("write response late");
    AST_R_LAT: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read response late");
    AST_ACT_RISE: assert property ($rose(monitor_active_o) |-> $past(monitor_enable_i)
        || $past(monitor_enable_i, 2)) else $error("monitor started while disabled");
    AST_ACT_FALL: assert property ($fell(monitor_active_o) |-> $past(rx_word_valid_i)
        || !$past(monitor_enable_i) || !$past(monitor_enable_i, 2)) else $error("monitor stopped without cause");
    AST_IRQ_RISE: assert property ($rose(irq_o) |-> $rose(s_axi_bvalid_o) || $past(rx_word_valid_i)
        || $past(external_start_input_i)) else $error("interrupt without event");
    cover property ($rose(monitor_active_o));
    cover property ($fell(monitor_active_o));
    cover property ($rose(irq_o));
endmodule

//--- mtc_host_model.sv
`timescale 1ns/100ps
module mtc_host_model (
    input  wire logic        clk_i, awready_i, wready_i, bvalid_i, arready_i, rvalid_i,
    input  wire logic [1:0]  bresp_i, rresp_i,
    input  wire logic [31:0] rdata_i,
    output logic [7:0]       awaddr_o, araddr_o,
    output logic [31:0]      wdata_o,
    output logic [3:0]       wstrb_o,
    output logic             awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o
);
    // Response ready stays high, so it never toggles within one step.
    initial begin
        {awaddr_o, araddr_o, wdata_o, wstrb_o, awvalid_o, wvalid_o, arvalid_o} = '0;
        {bready_o, rready_o} = 2'h3;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_n = 1'b1, w_n = 1'b1;
        awaddr_o <= a;
        wdata_o <= d;
        wstrb_o <= 4'hF;
        awvalid_o <= 1'b1;
        wvalid_o <= 1'b1;
        while (aw_n || w_n) begin
            @(posedge clk_i);
            if (aw_n && awready_i) begin
                aw_n = 1'b0;
                awvalid_o <= 1'b0;
            end
            if (w_n && wready_i) begin
                w_n = 1'b0;
                wvalid_o <= 1'b0;
            end
        end
        do @(posedge clk_i); while (bvalid_i !== 1'b1);
        r = bresp_i;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr_o <= a;
        arvalid_o <= 1'b1;
        do @(posedge clk_i); while (arready_i !== 1'b1);
        arvalid_o <= 1'b0;
        do @(posedge clk_i); while (rvalid_i !== 1'b1);
        d = rdata_i;
        r = rresp_i;
    endtask
endmodule

//--- tb_top.sv
`timescale 1ns/100ps
module tb_top;
    typedef struct packed {
        logic [15:0] wd;
        logic [8:0]  ex;
    } mtc_row_t;
    logic        ref_clk_i = 1'b0;
    logic        sys_rst_i, monitor_enable_i, rx_word_valid_i, external_start_input_i, monitor_active_o, irq_o;
    logic [15:0] rx_word_i;
    logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd_d;
    logic [3:0]  s_axi_wstrb_i;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, rsp;
    logic        s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i;
    logic        s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i, enhanced_irq_enable_o;
    logic        ram_parity_enable_o, busy_table_enable_o, double_buffer_enable_o, overwrite_invalid_enable_o;
    logic        buffer_wrap_256_o;
    logic [2:0]  time_tag_res_o;
    int          err_total, n_checks;
    mtc_row_t    rows [8] = '{'{16'h8000, 9'h108}, '{16'h4080, 9'h089}, '{16'h2100, 9'h04A}, '{16'h1180, 9'h02B},
                              '{16'h0A00, 9'h01C}, '{16'h0680, 9'h005}, '{16'hFF7F, 9'h1F6}, '{16'h0380, 9'h00F}};
    always #25 ref_clk_i = ~ref_clk_i;
    mtc_config_regs u_dut (.ref_clk_i, .sys_rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
        .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
        .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
        .s_axi_rvalid_o, .s_axi_rready_i, .monitor_enable_i, .rx_word_valid_i, .rx_word_i, .external_start_input_i,
        .monitor_active_o, .enhanced_irq_enable_o, .ram_parity_enable_o, .busy_table_enable_o,
        .double_buffer_enable_o, .overwrite_invalid_enable_o, .buffer_wrap_256_o, .time_tag_res_o, .irq_o);
    mtc_host_model u_host (.clk_i(ref_clk_i), .awready_i(s_axi_awready_o), .wready_i(s_axi_wready_o),
        .bvalid_i(s_axi_bvalid_o), .arready_i(s_axi_arready_o), .rvalid_i(s_axi_rvalid_o), .bresp_i(s_axi_bresp_o),
        .rresp_i(s_axi_rresp_o), .rdata_i(s_axi_rdata_o), .awaddr_o(s_axi_awaddr_i), .araddr_o(s_axi_araddr_i),
        .wdata_o(s_axi_wdata_i), .wstrb_o(s_axi_wstrb_i), .awvalid_o(s_axi_awvalid_i), .wvalid_o(s_axi_wvalid_i),
        .bready_o(s_axi_bready_i), .arvalid_o(s_axi_arvalid_i), .rready_o(s_axi_rready_i));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        u_host.wr(a, d, rsp);
        chk({30'h0, rsp}, {30'h0, mtc_pkg::RESP_OKAY});
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] e);
        u_host.rd(a, rd_d, rsp);
        chk(rd_d, e);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    task automatic send(input logic [15:0] w);
        rx_word_i <= w;
        rx_word_valid_i <= 1'b1;
        cyc(1);
        rx_word_valid_i <= 1'b0;
        cyc(3);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        cyc(4000);
        err_total++;
        $display("[ERR] %0t watchdog expired", $time);
        wrap_up;
    end
    initial begin
        {sys_rst_i, monitor_enable_i, rx_word_valid_i, rx_word_i, external_start_input_i} = {1'b1, 19'h0};
        cyc(6);
        sys_rst_i <= 1'b0;
        cyc(1);
        rreg(mtc_pkg::ADDR_CONFIG_TWO, 32'h0);
        rreg(mtc_pkg::ADDR_CONFIG_ONE, 32'h0);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            wreg(mtc_pkg::ADDR_CONFIG_TWO, {16'hFFFF, rows[i].wd});
            chk({23'h0, enhanced_irq_enable_o, ram_parity_enable_o, busy_table_enable_o, double_buffer_enable_o,
                 overwrite_invalid_enable_o, buffer_wrap_256_o, time_tag_res_o}, {23'h0, rows[i].ex});
            rreg(mtc_pkg::ADDR_CONFIG_TWO, {16'h0, rows[i].wd & 16'hFF80});
        end
        $display("config two table done");
        wreg(mtc_pkg::ADDR_CONFIG_ONE, 32'hFFFF_FFFF);
        rreg(mtc_pkg::ADDR_CONFIG_ONE, 32'h0E80);
        u_host.wr(8'h40, 32'h1, rsp);
        chk({30'h0, rsp}, {30'h0, mtc_pkg::RESP_SLVERR});
        u_host.rd(8'h40, rd_d, rsp);
        chk({rd_d[29:0], rsp}, {30'h0, mtc_pkg::RESP_SLVERR});
        wreg(mtc_pkg::ADDR_CONFIG_ONE, 32'h0080);
        monitor_enable_i <= 1'b1;
        cyc(4);
        external_start_input_i <= 1'b1;
        cyc(3);
        external_start_input_i <= 1'b0;
        rreg(mtc_pkg::ADDR_CONFIG_ONE, 32'h0085);
        monitor_enable_i <= 1'b0;
        cyc(4);
        wreg(mtc_pkg::ADDR_CONFIG_ONE, 32'h0880);
        monitor_enable_i <= 1'b1;
        cyc(4);
        chk(32'(monitor_active_o), 32'h0);
        external_start_input_i <= 1'b1;
        cyc(3);
        chk(32'(monitor_active_o), 32'h1);
        rreg(mtc_pkg::ADDR_CONFIG_ONE, 32'h0887);
        $display("external start test done");
        {monitor_enable_i, external_start_input_i} <= 2'h0;
        cyc(4);
        wreg(mtc_pkg::ADDR_IRQ_STATUS, 32'h7);
        wreg(mtc_pkg::ADDR_TRIGGER_WORD, 32'h1234);
        wreg(mtc_pkg::ADDR_CONFIG_ONE, 32'h0C00);
        monitor_enable_i <= 1'b1;
        send(16'h1233);
        chk(32'(monitor_active_o), 32'h0);
        send(16'h1234);
        chk({31'h0, monitor_active_o, irq_o}, 32'h2);
        rreg(mtc_pkg::ADDR_CONFIG_ONE, 32'h0C07);
        rreg(mtc_pkg::ADDR_IRQ_STATUS, 32'h3);
        wreg(mtc_pkg::ADDR_IRQ_MASK, 32'h1);
        chk(32'(irq_o), 32'h1);
        wreg(mtc_pkg::ADDR_IRQ_STATUS, 32'h1);
        chk(32'(irq_o), 32'h0);
        wreg(mtc_pkg::ADDR_CONFIG_ONE, 32'h0E00);
        send(16'h1234);
        chk(32'(monitor_active_o), 32'h0);
        rreg(mtc_pkg::ADDR_IRQ_STATUS, 32'h7);
        wreg(mtc_pkg::ADDR_IRQ_MASK, 32'h0);
        $display("trigger word test done");
        sys_rst_i <= 1'b1;
        cyc(2);
        sys_rst_i <= 1'b0;
        cyc(1);
        rreg(mtc_pkg::ADDR_CONFIG_TWO, 32'h0);
        chk(32'(buffer_wrap_256_o), 32'h1);
        $display("second reset test done");
        wrap_up;
    end
endmodule
bind mtc_config_regs mtc_config_regs_monitor u_mon (.ref_clk_i, .sys_rst_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o,
    .monitor_enable_i, .rx_word_valid_i, .external_start_input_i, .monitor_active_o, .enhanced_irq_enable_o,
    .buffer_wrap_256_o, .irq_o, .time_tag_res_o);
